// ===== core/cpu_opcode_flags_and_timing.sv
// Opcode decode, flag update, state-count and block-copy engine of a small CPU core.
// Assumes software drives the register port and on-chip memory answers a read next cycle.
//
// Operation
// - Half-carry set on carry or borrow out of bit 11 in word arithmetic.
// - Add/subtract with carry keep zero flag on zero result, else clear it.
// - Decimal adjust sets carry on adjust carry, else keeps prior carry.
// - Block copy takes 4n + 9 states, n the initial count low byte.
// - Divide sets sign flag when divisor is negative, else clears it.
// - Divide sets zero flag when divisor is zero, else clears it.
// - Primary opcode is bits 15 to 8 of the first instruction word.
// - Shared opcode slots choose instruction by bit 7 of first word; the decode ignores bit 7 and only reports it in status.
// - Push and pop execute as the data transfer they encode as.
// - Execution states are the sum of cycle counts times state costs.
// - Fetch, branch-address read and stack cycles on-chip take 2 states.
// - Byte access to a peripheral takes 2 or 3 states per module.
// - Block copy moves bytes source to destination, bumping pointers, until count zero.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module cpu_opcode_flags_and_timing (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output cpu_opcode_pkg::memReq_s memReq,
  input wire logic [7:0] memRdata,
  output logic busy
);
  import cpu_opcode_pkg::*;

  logic [15:0] instr_q;
  logic [15:0] opA_q;
  logic [15:0] opB_q;
  logic [7:0] ccr_q;
  logic [27:0] cycles_q;
  logic [7:0] slowMask_q;
  logic [15:0] result_q;
  logic [15:0] states_q;
  logic [7:0] count_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [7:0] copyData_q;
  logic [3:0] setup_q;
  logic [31:0] regRdata_q;
  memReq_s memReq_q;
  copyState_e copyState_q;
  copyState_e copyState_d;

  logic [7:0] opcode;
  logic altSel;
  opClass_e opClass;
  logic useImm;
  logic [15:0] opB;
  logic execGo;
  logic [15:0] execRes;
  logic [7:0] execCcr;
  logic [15:0] execStates;
  logic [15:0] costSum;
  logic [3:0] byteCost;
  logic [15:0] copyStates;
  logic [16:0] sum17;
  logic [12:0] sum13;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] daCorr;
  logic daHi;
  logic daLo;
  logic [15:0] quot;
  logic [15:0] rem;

  assign opcode = instr_q[15:8];
  assign altSel = instr_q[7];

  always_comb begin
    useImm = 1'b0;
    opClass = CL_OTHER;
    case (opcode)
      OPC_ADD_W: opClass = CL_ADD_W;
      OPC_SUB_W: opClass = CL_SUB_W;
      OPC_ADD_CARRY: opClass = CL_ADD_CARRY;
      OPC_SUB_BORROW: opClass = CL_SUB_BORROW;
      OPC_ADJ_ADD: opClass = CL_ADJ_ADD;
      OPC_ADJ_SUB: opClass = CL_ADJ_SUB;
      OPC_DIV: opClass = CL_DIV;
      OPC_COPY: opClass = CL_COPY;
      OPC_MOVE_B, OPC_MOVE_W: opClass = CL_MOVE;
      OPC_BIT_ST: opClass = CL_BITOP;
      default: begin
        if (opcode[7:4] == HI_ADD_CARRY) begin
          opClass = CL_ADD_CARRY;
          useImm = 1'b1;
        end else if (opcode[7:4] == HI_SUB_BORROW) begin
          opClass = CL_SUB_BORROW;
          useImm = 1'b1;
        end else if (opcode[7:4] == HI_MOVE_IMM) begin
          opClass = CL_MOVE;
          useImm = 1'b1;
        end else if (opcode[7:4] == HI_MOVE_EXT && opcode[3]) begin
          opClass = CL_MOVE;
        end else if (opcode[7:4] == HI_BIT_X && opcode[3:2] == 2'b01) begin
          opClass = CL_BITOP;
        end else begin
          opClass = CL_OTHER;
        end
      end
    endcase
  end

  assign opB = useImm ? {8'h00, instr_q[7:0]} : opB_q;

  assign byteCost = !cycles_q[CYC_PERIPH] ? ST_BYTE_MEM
    : (slowMask_q[cycles_q[CYC_MODULE +: 3]] ? ST_BYTE_SLOW : ST_BYTE_FAST);

  // internal and word costs.
  // Operands are widened before the product so a 4-bit product cannot wrap.
  assign costSum = 16'(cycles_q[CYC_I +: 4]) * 16'(ST_FETCH)
    + 16'(cycles_q[CYC_J +: 4]) * 16'(ST_BRANCH)
    + 16'(cycles_q[CYC_K +: 4]) * 16'(ST_STACK)
    + 16'(cycles_q[CYC_L +: 4]) * 16'(byteCost)
    + 16'(cycles_q[CYC_M +: 4]) * 16'(ST_WORD_MEM)
    + 16'(cycles_q[CYC_N +: 4]) * 16'(ST_INTERNAL);

  assign copyStates = 16'(count_q) * 16'(COPY_PER_BYTE) + 16'(COPY_FIXED);

  assign execGo = regWr && regAddr == OFS_CMD && regWdata[0] && copyState_q == CP_IDLE;

  always_comb begin
    execRes = result_q;
    execCcr = ccr_q;
    execStates = costSum;
    sum17 = 17'h00000;
    sum13 = 13'h0000;
    sum9 = 9'h000;
    sum5 = 5'h00;
    daCorr = 8'h00;
    daHi = 1'b0;
    daLo = 1'b0;
    quot = 16'h0000;
    rem = 16'h0000;
    case (opClass)
      CL_ADD_W: begin
        sum17 = {1'b0, opA_q} + {1'b0, opB};
        sum13 = {1'b0, opA_q[11:0]} + {1'b0, opB[11:0]};
        execRes = sum17[15:0];
        execCcr[CCR_H] = sum13[12];
        execCcr[CCR_C] = sum17[16];
        execCcr[CCR_N] = sum17[15];
        execCcr[CCR_Z] = sum17[15:0] == 16'h0000;
        execCcr[CCR_V] = (opA_q[15] == opB[15]) && (sum17[15] != opA_q[15]);
      end
      CL_SUB_W: begin
        sum17 = {1'b0, opA_q} - {1'b0, opB};
        sum13 = {1'b0, opA_q[11:0]} - {1'b0, opB[11:0]};
        execRes = sum17[15:0];
        execCcr[CCR_H] = sum13[12];
        execCcr[CCR_C] = sum17[16];
        execCcr[CCR_N] = sum17[15];
        execCcr[CCR_Z] = sum17[15:0] == 16'h0000;
        execCcr[CCR_V] = (opA_q[15] != opB[15]) && (sum17[15] != opA_q[15]);
      end
      CL_ADD_CARRY: begin
        sum9 = {1'b0, opA_q[7:0]} + {1'b0, opB[7:0]} + {8'h00, ccr_q[CCR_C]};
        sum5 = {1'b0, opA_q[3:0]} + {1'b0, opB[3:0]} + {4'h0, ccr_q[CCR_C]};
        execRes = {opA_q[15:8], sum9[7:0]};
        execCcr[CCR_H] = sum5[4];
        execCcr[CCR_C] = sum9[8];
        execCcr[CCR_N] = sum9[7];
        execCcr[CCR_V] = (opA_q[7] == opB[7]) && (sum9[7] != opA_q[7]);
        execCcr[CCR_Z] = (sum9[7:0] == 8'h00) ? ccr_q[CCR_Z] : 1'b0;
      end
      CL_SUB_BORROW: begin
        sum9 = {1'b0, opA_q[7:0]} - {1'b0, opB[7:0]} - {8'h00, ccr_q[CCR_C]};
        sum5 = {1'b0, opA_q[3:0]} - {1'b0, opB[3:0]} - {4'h0, ccr_q[CCR_C]};
        execRes = {opA_q[15:8], sum9[7:0]};
        execCcr[CCR_H] = sum5[4];
        execCcr[CCR_C] = sum9[8];
        execCcr[CCR_N] = sum9[7];
        execCcr[CCR_V] = (opA_q[7] != opB[7]) && (sum9[7] != opA_q[7]);
        execCcr[CCR_Z] = (sum9[7:0] == 8'h00) ? ccr_q[CCR_Z] : 1'b0;
      end
      CL_ADJ_ADD: begin
        daLo = ccr_q[CCR_H] || opA_q[3:0] > 4'h9;
        daHi = ccr_q[CCR_C] || opA_q[7:0] > 8'h99;
        daCorr = {daHi ? 4'h6 : 4'h0, daLo ? 4'h6 : 4'h0};
        sum9 = {1'b0, opA_q[7:0]} + {1'b0, daCorr};
        execRes = {opA_q[15:8], sum9[7:0]};
        execCcr[CCR_N] = sum9[7];
        execCcr[CCR_Z] = sum9[7:0] == 8'h00;
        execCcr[CCR_C] = ccr_q[CCR_C] | daHi;
      end
      CL_ADJ_SUB: begin
        daCorr = {ccr_q[CCR_C] ? 4'h6 : 4'h0, ccr_q[CCR_H] ? 4'h6 : 4'h0};
        sum9 = {1'b0, opA_q[7:0]} - {1'b0, daCorr};
        execRes = {opA_q[15:8], sum9[7:0]};
        execCcr[CCR_N] = sum9[7];
        execCcr[CCR_Z] = sum9[7:0] == 8'h00;
        execCcr[CCR_C] = ccr_q[CCR_C] | sum9[8];
      end
      CL_DIV: begin
        // Division by zero leaves the dividend in place rather than inventing a quotient.
        if (opB[7:0] != 8'h00) begin
          quot = opA_q / {8'h00, opB[7:0]};
          rem = opA_q % {8'h00, opB[7:0]};
          execRes = {rem[7:0], quot[7:0]};
        end else begin
          execRes = opA_q;
        end
        execCcr[CCR_N] = opB[7];
        execCcr[CCR_Z] = opB[7:0] == 8'h00;
      end
      CL_MOVE: begin
        execRes = opB;
        execCcr[CCR_N] = opB[15];
        execCcr[CCR_Z] = opB == 16'h0000;
        execCcr[CCR_V] = 1'b0;
      end
      CL_COPY: begin
        execStates = copyStates;
      end
      default: begin
        execRes = result_q;
      end
    endcase
  end

  // Software writes to registers the engine also updates are dropped while copying.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_q <= RST_INSTR;
      opA_q <= RST_WORD;
      opB_q <= RST_WORD;
      cycles_q <= 28'h0000000;
      slowMask_q <= RST_SLOW;
    end else if (regWr) begin
      case (regAddr)
        OFS_INSTR: instr_q <= regWdata[15:0];
        OFS_OPA: opA_q <= regWdata[15:0];
        OFS_OPB: opB_q <= regWdata[15:0];
        OFS_CYCLES: cycles_q <= regWdata[27:0];
        OFS_SLOW: slowMask_q <= regWdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ccr_q <= RST_CCR;
      result_q <= RST_WORD;
      states_q <= RST_WORD;
    end else if (execGo) begin
      ccr_q <= execCcr;
      result_q <= execRes;
      states_q <= execStates;
    end else if (regWr && regAddr == OFS_CCR) begin
      ccr_q <= regWdata[7:0];
    end
  end

  always_comb begin
    copyState_d = copyState_q;
    case (copyState_q)
      CP_IDLE: begin
        if (execGo && opClass == CL_COPY) begin
          copyState_d = CP_SETUP;
        end
      end
      CP_SETUP: begin
        if (setup_q == 4'h1) begin
          copyState_d = (count_q != 8'h00) ? CP_READ : CP_IDLE;
        end
      end
      CP_READ: copyState_d = CP_RDWAIT;
      CP_RDWAIT: copyState_d = CP_WRITE;
      CP_WRITE: copyState_d = CP_WRWAIT;
      // The count still holds the byte being finished, so one means last byte.
      CP_WRWAIT: copyState_d = (count_q != 8'h01) ? CP_READ : CP_IDLE;
      default: copyState_d = CP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      copyState_q <= CP_IDLE;
      setup_q <= 4'h0;
    end else begin
      copyState_q <= copyState_d;
      if (copyState_q == CP_IDLE) begin
        setup_q <= COPY_FIXED;
      end else if (copyState_q == CP_SETUP) begin
        setup_q <= setup_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 8'h00;
      src_q <= RST_WORD;
      dst_q <= RST_WORD;
      copyData_q <= 8'h00;
    end else if (copyState_q == CP_IDLE) begin
      if (regWr && regAddr == OFS_COUNT) begin
        count_q <= regWdata[7:0];
      end
      if (regWr && regAddr == OFS_SRC) begin
        src_q <= regWdata[15:0];
      end
      if (regWr && regAddr == OFS_DST) begin
        dst_q <= regWdata[15:0];
      end
    end else if (copyState_q == CP_RDWAIT) begin
      copyData_q <= memRdata;
      src_q <= src_q + 16'h0001;
    end else if (copyState_q == CP_WRWAIT) begin
      dst_q <= dst_q + 16'h0001;
      count_q <= count_q - 8'h01;
    end
  end

  // Memory strobes are registered so they line up with the read and write states.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memReq_q <= '0;
    end else begin
      memReq_q.rd <= copyState_d == CP_READ;
      memReq_q.wr <= copyState_d == CP_WRITE;
      memReq_q.addr <= (copyState_d == CP_WRITE) ? dst_q : src_q;
      memReq_q.wdata <= (copyState_d == CP_WRITE) ? memRdata : copyData_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata_q <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        OFS_INSTR: regRdata_q <= {16'h0000, instr_q};
        OFS_OPA: regRdata_q <= {16'h0000, opA_q};
        OFS_OPB: regRdata_q <= {16'h0000, opB_q};
        OFS_CCR: regRdata_q <= {24'h000000, ccr_q};
        OFS_CYCLES: regRdata_q <= {4'h0, cycles_q};
        OFS_SLOW: regRdata_q <= {24'h000000, slowMask_q};
        OFS_RESULT: regRdata_q <= {16'h0000, result_q};
        OFS_STATES: regRdata_q <= {16'h0000, states_q};
        OFS_COUNT: regRdata_q <= {24'h000000, count_q};
        OFS_SRC: regRdata_q <= {16'h0000, src_q};
        OFS_DST: regRdata_q <= {16'h0000, dst_q};
        OFS_STATUS: regRdata_q <= {24'h000000, opClass, 2'b00, altSel,
                                   copyState_q != CP_IDLE};
        default: regRdata_q <= 32'h00000000;
      endcase
    end else begin
      regRdata_q <= 32'h00000000;
    end
  end

  assign regRdata = regRdata_q;
  assign memReq = memReq_q;
  assign busy = copyState_q != CP_IDLE;

endmodule

// ===== shared/cpu_opcode_pkg.sv
// Shared constants and types for the CPU opcode, flag and timing block.
// Assumes a single 200 MHz clock where one execution state is one clock cycle.
package cpu_opcode_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_OPA = 8'h04;
  localparam logic [7:0] OFS_OPB = 8'h08;
  localparam logic [7:0] OFS_CCR = 8'h0c;
  localparam logic [7:0] OFS_CYCLES = 8'h10;
  localparam logic [7:0] OFS_SLOW = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h1c;
  localparam logic [7:0] OFS_STATES = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  localparam logic [7:0] OFS_SRC = 8'h28;
  localparam logic [7:0] OFS_DST = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;

  // Reset values.
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_CCR = 8'h80;
  localparam logic [7:0] RST_SLOW = 8'h00;

  // Condition code bit positions.
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_H = 5;

  // Cycle-count register fields: six 4-bit counts, then peripheral select.
  localparam int CYC_I = 0;
  localparam int CYC_J = 4;
  localparam int CYC_K = 8;
  localparam int CYC_L = 12;
  localparam int CYC_M = 16;
  localparam int CYC_N = 20;
  localparam int CYC_PERIPH = 24;
  localparam int CYC_MODULE = 25;

  // Status register fields.
  localparam int STS_BUSY = 0;
  localparam int STS_ALT = 1;
  localparam int STS_CLASS = 4;

  // State cost of each cycle type.
  localparam logic [3:0] ST_FETCH = 4'h2;
  localparam logic [3:0] ST_BRANCH = 4'h2;
  localparam logic [3:0] ST_STACK = 4'h2;
  localparam logic [3:0] ST_BYTE_MEM = 4'h2;
  localparam logic [3:0] ST_WORD_MEM = 4'h2;
  localparam logic [3:0] ST_INTERNAL = 4'h1;
  localparam logic [3:0] ST_BYTE_FAST = 4'h2;
  localparam logic [3:0] ST_BYTE_SLOW = 4'h3;

  // Block copy timing: fixed part plus a per-byte part.
  localparam logic [3:0] COPY_FIXED = 4'h9;
  localparam logic [3:0] COPY_PER_BYTE = 4'h4;

  // Primary opcodes (first byte of the instruction word).
  localparam logic [7:0] OPC_ADD_W = 8'h09;
  localparam logic [7:0] OPC_SUB_W = 8'h19;
  localparam logic [7:0] OPC_ADD_CARRY = 8'h0e;
  localparam logic [7:0] OPC_SUB_BORROW = 8'h1e;
  localparam logic [7:0] OPC_ADJ_ADD = 8'h0f;
  localparam logic [7:0] OPC_ADJ_SUB = 8'h1f;
  localparam logic [7:0] OPC_DIV = 8'h51;
  localparam logic [7:0] OPC_COPY = 8'h7b;
  localparam logic [7:0] OPC_MOVE_B = 8'h0c;
  localparam logic [7:0] OPC_MOVE_W = 8'h0d;
  localparam logic [7:0] OPC_BIT_ST = 8'h67;
  localparam logic [3:0] HI_ADD_CARRY = 4'h9;
  localparam logic [3:0] HI_SUB_BORROW = 4'hb;
  localparam logic [3:0] HI_MOVE_IMM = 4'hf;
  localparam logic [3:0] HI_MOVE_EXT = 4'h6;
  localparam logic [3:0] HI_BIT_X = 4'h7;

  typedef enum logic [3:0] {
    CL_OTHER = 4'b0000,
    CL_ADD_W = 4'b0001,
    CL_SUB_W = 4'b0010,
    CL_ADD_CARRY = 4'b0011,
    CL_SUB_BORROW = 4'b0100,
    CL_ADJ_ADD = 4'b0101,
    CL_ADJ_SUB = 4'b0110,
    CL_DIV = 4'b0111,
    CL_COPY = 4'b1000,
    CL_MOVE = 4'b1001,
    CL_BITOP = 4'b1010
  } opClass_e;

  typedef enum logic [2:0] {
    CP_IDLE = 3'b000,
    CP_SETUP = 3'b001,
    CP_READ = 3'b010,
    CP_RDWAIT = 3'b011,
    CP_WRITE = 3'b100,
    CP_WRWAIT = 3'b101
  } copyState_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } memReq_s;

endpackage

// ===== test/onchip_mem_model.sv
// Byte-wide on-chip memory that answers the copy engine.
// Assumes read data is wanted only in the cycle after a read strobe.
`timescale 1ns/10ps
module onchip_mem_model (
  input wire logic clk,
  input wire cpu_opcode_pkg::memReq_s memReq,
  output logic [7:0] memRdata
);
  import cpu_opcode_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] rdByte_q = 8'h00;
  logic rdValid_q = 1'b0;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  always @(posedge clk) begin
    rdValid_q <= memReq.rd;
    if (memReq.rd) begin
      rdByte_q <= mem[memReq.addr[7:0]];
    end
    if (memReq.wr) begin
      mem[memReq.addr[7:0]] <= memReq.wdata;
    end
  end
  // Outside the answer cycle the bus shows the inverse, so a late sample cannot pass.
  assign memRdata = rdValid_q ? rdByte_q : ~rdByte_q;
endmodule

// ===== test/cpu_opcode_flags_and_timing_assertions.sv
// Concurrent checks on the register port and the copy engine.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/10ps
module cpu_opcode_flags_and_timing_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire cpu_opcode_pkg::memReq_s memReq,
  input wire logic [7:0] memRdata,
  input wire logic busy
);
  import cpu_opcode_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rdata_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  rd_pulse_a: assert property (memReq.rd |=> !memReq.rd)
    else $error("read strobe longer than one cycle");
  rd_wr_excl_a: assert property (!(memReq.rd && memReq.wr))
    else $error("read and write strobes together");
  rd_then_wr_a: assert property (memReq.rd |-> ##2 (memReq.wr && busy))
    else $error("write does not follow read by two cycles");
  wr_data_a: assert property (memReq.rd |-> ##2 memReq.wdata == $past(memRdata))
    else $error("written byte differs from byte read");
  idle_quiet_a: assert property (!busy |-> !memReq.rd && !memReq.wr)
    else $error("memory strobe while idle");
  setup_len_a: assert property ($rose(busy) |-> (busy && !memReq.rd)[*8]
    ##1 (busy && !memReq.rd) ##1 (memReq.rd || !busy))
    else $error("copy setup not nine cycles");
  byte_period_a: assert property (memReq.rd |-> busy[*4] ##1 (memReq.rd || !busy))
    else $error("byte transfer not four cycles");
  src_step_a: assert property (memReq.rd |-> ##4
    (!memReq.rd || memReq.addr == $past(memReq.addr, 4) + 16'h1))
    else $error("source address not incremented");
  dst_step_a: assert property (memReq.wr |-> ##4
    (!memReq.wr || memReq.addr == $past(memReq.addr, 4) + 16'h1))
    else $error("destination address not incremented");
endmodule
bind cpu_opcode_flags_and_timing cpu_opcode_flags_and_timing_checker chk0 (.clk(clk),
  .sys_rst(sys_rst), .regRd(regRd), .regRdata(regRdata), .memReq(memReq),
  .memRdata(memRdata), .busy(busy));

// ===== test/testbench.sv
// Self-checking bench for the opcode, flag and timing block.
// Assumes the on-chip memory model answers the copy engine.
`timescale 1ns/10ps
module testbench;
  import cpu_opcode_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  memReq_s memReq;
  logic [7:0] memRdata;
  logic busy;
  int miscompares = 0;
  int cmp_count = 0;
  cpu_opcode_flags_and_timing DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .memReq(memReq), .memRdata(memRdata), .busy(busy));
  onchip_mem_model mem0 (.clk(clk), .memReq(memReq), .memRdata(memRdata));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    cmp(regRdata & m, e);
  endtask
  task automatic ex(input logic [15:0] i, input logic [15:0] a, input logic [15:0] b,
    input logic [7:0] ccr);
    wr(OFS_CCR, {24'h0, ccr});
    wr(OFS_INSTR, {16'h0, i});
    wr(OFS_OPA, {16'h0, a});
    wr(OFS_OPB, {16'h0, b});
    wr(OFS_CMD, 32'h1);
  endtask
  task automatic t_reset();
    rdc(OFS_CCR, 32'hff, 32'h80);
    rdc(8'hfc, 32'hffffffff, 32'h0);
    rdc(OFS_RESULT, 32'hffffffff, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_flags();
    ex(16'h0900, 16'h0800, 16'h0800, 8'h00);
    rdc(OFS_CCR, 32'h2f, 32'h20);
    rdc(OFS_RESULT, 32'hffff, 32'h1000);
    ex(16'h0900, 16'h0700, 16'h0700, 8'h00);
    rdc(OFS_CCR, 32'h2f, 32'h00);
    ex(16'h1900, 16'h1000, 16'h0001, 8'h00);
    rdc(OFS_CCR, 32'h2f, 32'h20);
    ex(16'h0e00, 16'h00ff, 16'h0001, 8'h04);
    rdc(OFS_CCR, 32'h05, 32'h05);
    ex(16'h9001, 16'h00ff, 16'h0000, 8'h00);
    rdc(OFS_CCR, 32'h05, 32'h01);
    ex(16'h1e00, 16'h0010, 16'h0005, 8'h05);
    rdc(OFS_CCR, 32'h05, 32'h00);
    rdc(OFS_RESULT, 32'hffff, 32'h000a);
    ex(16'hb001, 16'h0002, 16'h0000, 8'h05);
    rdc(OFS_CCR, 32'h05, 32'h04);
    $display("t_flags done");
  endtask
  task automatic t_adjust_div();
    ex(16'h0f00, 16'h0012, 16'h0000, 8'h01);
    rdc(OFS_CCR, 32'h01, 32'h01);
    rdc(OFS_RESULT, 32'hff, 32'h72);
    ex(16'h0f00, 16'h009a, 16'h0000, 8'h00);
    rdc(OFS_CCR, 32'h01, 32'h01);
    ex(16'h0f00, 16'h0012, 16'h0000, 8'h00);
    rdc(OFS_CCR, 32'h01, 32'h00);
    ex(16'h1f00, 16'h0075, 16'h0000, 8'h01);
    rdc(OFS_CCR, 32'h01, 32'h01);
    rdc(OFS_RESULT, 32'hff, 32'h15);
    ex(16'h5100, 16'h0064, 16'h0007, 8'h00);
    rdc(OFS_CCR, 32'h0c, 32'h00);
    rdc(OFS_RESULT, 32'hffff, 32'h020e);
    ex(16'h5100, 16'h0064, 16'h0000, 8'h00);
    rdc(OFS_CCR, 32'h0c, 32'h04);
    ex(16'h5100, 16'h0064, 16'h0085, 8'h04);
    rdc(OFS_CCR, 32'h0c, 32'h08);
    $display("t_adjust_div done");
  endtask
  task automatic t_decode();
    logic [15:0] ins [13] = '{16'h0955, 16'h19aa, 16'h0e00, 16'h1e00, 16'h0f00, 16'h1f00,
      16'h5100, 16'h0c80, 16'h6d80, 16'hf012, 16'h6780, 16'h7500, 16'h0000};
    logic [3:0] cls [13] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'h9, 4'h9,
      4'ha, 4'ha, 4'h0};
    for (int i = 0; i < 13; i++) begin
      ex(ins[i], 16'h0012, 16'h0003, 8'h00);
      rdc(OFS_STATUS, 32'hf2, {24'h0, cls[i], 2'b00, ins[i][7], 1'b0});
    end
    $display("t_decode done");
  endtask
  task automatic t_states();
    wr(OFS_CYCLES, 32'h00213112);
    ex(16'h0000, 16'h0000, 16'h0000, 8'h00);
    rdc(OFS_STATES, 32'hffff, 32'h12);
    wr(OFS_CYCLES, 32'h05213112);
    wr(OFS_SLOW, 32'h04);
    ex(16'h0000, 16'h0000, 16'h0000, 8'h00);
    rdc(OFS_STATES, 32'hffff, 32'h15);
    wr(OFS_SLOW, 32'hfb);
    ex(16'h0000, 16'h0000, 16'h0000, 8'h00);
    rdc(OFS_STATES, 32'hffff, 32'h12);
    $display("t_states done");
  endtask
  task automatic t_copy(input int n, input logic [7:0] s, input logic [7:0] d);
    int cnt;
    cnt = 2;
    wr(OFS_COUNT, 32'(n));
    wr(OFS_SRC, {24'h0, s});
    wr(OFS_DST, {24'h0, d});
    wr(OFS_INSTR, 32'h7b00);
    wr(OFS_CMD, 32'h1);
    // This write lands while busy and must be ignored.
    wr(OFS_DST, 32'h00f0);
    #1;
    while (busy === 1'b1 && cnt < 2000) begin
      cnt++;
      @(posedge clk);
      #1;
    end
    cmp(32'(cnt), 32'(4 * n + 9));
    for (int k = 0; k < n; k++) begin
      cmp({24'h0, mem0.mem[d + k]}, {24'h0, (s + 8'(k)) ^ 8'h5a});
    end
    rdc(OFS_STATES, 32'hffff, 32'(4 * n + 9));
    rdc(OFS_SRC, 32'hffff, 32'(s) + 32'(n));
    rdc(OFS_DST, 32'hffff, 32'(d) + 32'(n));
    rdc(OFS_COUNT, 32'hff, 32'h0);
    $display("t_copy n=%0d done", n);
  endtask
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_flags();
    t_adjust_div();
    t_decode();
    t_states();
    t_copy(3, 8'h10, 8'h80);
    t_copy(0, 8'h20, 8'h90);
    print_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule
